// ### ppc_map.vh
// command offsets, field positions, reset values and timing figures of the port command registers
// included by every design file of the block; definitions only
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

// command offsets
`define PPC_CMD_PWR_EVT     8'h02
`define PPC_CMD_DET_EVT     8'h04
`define PPC_CMD_FLT_EVT     8'h06
`define PPC_CMD_SLI_EVT     8'h08
`define PPC_CMD_PWR_STAT    8'h10
`define PPC_CMD_INT_EN      8'h13
`define PPC_CMD_DC_EN       8'h14
`define PPC_CMD_DC_RESTART  8'h18
`define PPC_CMD_PWR_BTN     8'h19
`define PPC_CMD_RST_BTN     8'h1a
`define PPC_CMD_LEG_SEL     8'h20
`define PPC_CMD_TEC_SEL     8'h21
`define PPC_CMD_DEFER_TMR   8'h27

// reset push-button bits
`define PPC_RST_CLR_ALL     7
`define PPC_RST_REL_PIN     6
`define PPC_RST_ALL         4

// reset values
`define PPC_RST_VAL8        8'h00
`define PPC_RST_VAL4        4'h0
`define PPC_RST_VAL2        2'h0

// operating modes
`define PPC_MODE_OFF        2'h0
`define PPC_MODE_MANUAL     2'h1
`define PPC_MODE_SEMI       2'h2
`define PPC_MODE_AUTO       2'h3

// legacy detect select codes
`define PPC_LEG_STD         2'h0
`define PPC_LEG_ONLY        2'h1
`define PPC_LEG_STD_LEG     2'h2
`define PPC_LEG_RSVD        2'h3

// second class event select codes
`define PPC_TEC_OFF         2'h0
`define PPC_TEC_ON_A        2'h1
`define PPC_TEC_RSVD        2'h2
`define PPC_TEC_ON_B        2'h3

// event group order, shared by event vectors and interrupt enable bits
`define PPC_EV_PEC          0
`define PPC_EV_PGC          1
`define PPC_EV_DETC         2
`define PPC_EV_CLSC         3
`define PPC_EV_DISF         4
`define PPC_EV_ICUT         5
`define PPC_EV_ILIM         6
`define PPC_EV_STRT         7
`define PPC_EV_NC_MASK      8'h0f

// timing
`define PPC_T_STEP_MS       10
`define PPC_CLK_KHZ         10000

`endif

// ### ppc_defer_timer.v
// interrupt deferral timer: releases pending non-critical interrupts every N steps
// assumes a one-cycle load pulse whenever the count field is written
`timescale 1ns/1ps
`include "ppc_map.vh"

module ppc_defer_timer #(
  parameter STEP_CYCLES = 100000
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_srst,
  // control
  input  wire       i_load,
  input  wire [3:0] i_count,
  // release strobe
  output reg        o_release
);

  localparam SW = $clog2(STEP_CYCLES + 1);
  localparam [SW-1:0] STEP_LAST = STEP_CYCLES - 1;

  reg  [SW-1:0] step_q;
  reg  [3:0]    tcnt_q;
  wire          tick;

  assign tick = (step_q == STEP_LAST);

  // step divider and running count, reloaded at one
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_q    <= {SW{1'b0}};
      tcnt_q    <= `PPC_RST_VAL4;
      o_release <= 1'b0;
    end else if (i_srst || i_load) begin
      step_q    <= {SW{1'b0}};
      tcnt_q    <= i_srst ? `PPC_RST_VAL4 : i_count;
      o_release <= 1'b0;
    end else begin
      o_release <= 1'b0;
      step_q    <= tick ? {SW{1'b0}} : step_q + {{(SW-1){1'b0}}, 1'b1};
      if (tick && (i_count != `PPC_RST_VAL4)) begin
        if (tcnt_q <= 4'h1) begin
          o_release <= 1'b1;              // [RQ19]
          tcnt_q    <= i_count;           // [RQ19]
        end else begin
          tcnt_q <= tcnt_q - 4'h1;
        end
      end
    end
  end

endmodule

// ### ppc_port_ctl.v
// per-port power, event, enable and classification control
// assumes button and write strobes are one-cycle pulses on i_clk
`timescale 1ns/1ps
`include "ppc_map.vh"

module ppc_port_ctl (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_srst,
  // configuration
  input  wire [1:0] i_mode,
  input  wire [1:0] i_tec_sel,
  // command strobes
  input  wire       i_off_btn,
  input  wire       i_on_btn,
  input  wire       i_rst_btn,
  input  wire       i_rdet_btn,
  input  wire       i_rcls_btn,
  input  wire       i_en_wr,
  input  wire       i_cls_en_wd,
  input  wire       i_det_en_wd,
  input  wire       i_clr_all,
  // port engine
  input  wire       i_pg_in,
  input  wire       i_cooldown,
  input  wire       i_fault_off,
  input  wire       i_det_good,
  input  wire       i_det_legacy,
  input  wire [7:0] i_evt_set,
  // state
  output reg        o_pe,
  output reg        o_pg,
  output reg  [7:0] o_evt,
  output reg        o_cls_en,
  output reg        o_det_en,
  output reg        o_two_evt,
  // action strobes and detection run level
  output reg        o_clr_volt,
  output reg        o_clr_res,
  output reg        o_clr_stat,
  output reg        o_cd_cancel,
  output reg        o_det_go,
  output wire       o_det_run
);

  wire       semi_auto;
  wire       off_req;
  wire       on_req;
  wire       pe_d;
  wire       pg_d;
  wire [7:0] clr;
  wire [7:0] set;
  reg        arm_q;
  wire       tec_on;

  assign semi_auto = (i_mode == `PPC_MODE_SEMI) || (i_mode == `PPC_MODE_AUTO);
  assign off_req   = i_off_btn | i_rst_btn | i_fault_off;             // [RQ11] [RQ23]
  assign on_req    = (i_on_btn && (i_mode != `PPC_MODE_OFF) && ((i_mode == `PPC_MODE_MANUAL) || !i_cooldown))
                   || ((i_mode == `PPC_MODE_AUTO) && i_det_good && !i_det_legacy && !i_cooldown);   // [RQ16]
  assign pe_d      = off_req ? 1'b0 : (on_req ? 1'b1 : o_pe);         // [RQ3] [RQ13] [RQ23]
  assign pg_d      = off_req ? 1'b0 : (o_pe & i_pg_in);               // [RQ3] [RQ13]

  // off and reset buttons clear detection, fault and start events
  assign clr = {8{i_clr_all}} | ({8{i_off_btn | i_rst_btn}} & 8'hfc);  // [RQ2] [RQ11] [RQ7]
  assign set = i_evt_set
             | ({7'h00, o_pe != pe_d} << `PPC_EV_PEC)
             | ({7'h00, (o_pg != pg_d) || (off_req && o_pe)} << `PPC_EV_PGC);   // [RQ3] [RQ13]

  assign tec_on    = (i_tec_sel == `PPC_TEC_ON_A) || (i_tec_sel == `PPC_TEC_ON_B);
  assign o_det_run = semi_auto && o_det_en && !o_pe && !i_cooldown;   // [RQ15]

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pe        <= 1'b0;
      o_pg        <= 1'b0;
      o_evt       <= `PPC_RST_VAL8;
      o_cls_en    <= 1'b0;
      o_det_en    <= 1'b0;
      o_two_evt   <= 1'b0;
      arm_q       <= 1'b0;
      o_clr_volt  <= 1'b0;
      o_clr_res   <= 1'b0;
      o_clr_stat  <= 1'b0;
      o_cd_cancel <= 1'b0;
      o_det_go    <= 1'b0;
    end else if (i_srst) begin
      o_pe        <= 1'b0;
      o_pg        <= 1'b0;
      o_evt       <= `PPC_RST_VAL8;
      o_cls_en    <= 1'b0;
      o_det_en    <= 1'b0;
      o_two_evt   <= 1'b0;
      arm_q       <= 1'b0;
      o_clr_volt  <= 1'b0;
      o_clr_res   <= 1'b0;
      o_clr_stat  <= 1'b0;
      o_cd_cancel <= 1'b0;
      o_det_go    <= 1'b0;
    end else begin
      o_pe        <= pe_d;
      o_pg        <= pg_d;
      o_evt       <= (o_evt & ~clr) | set;                            // set wins over clear
      o_clr_volt  <= i_off_btn | i_rst_btn;                           // [RQ1] [RQ11]
      o_clr_stat  <= i_off_btn | i_rst_btn;                           // [RQ1] [RQ11]
      o_clr_res   <= i_off_btn;                                       // [RQ1]
      o_cd_cancel <= i_rst_btn & i_cooldown;                          // [RQ12]
      o_det_go    <= i_rdet_btn;                                      // [RQ15]
      if (i_off_btn || i_rst_btn) begin
        o_cls_en <= 1'b0;                                             // [RQ2] [RQ11]
        o_det_en <= 1'b0;                                             // [RQ2] [RQ11]
        arm_q    <= 1'b0;
      end else begin
        if (i_en_wr) begin
          o_cls_en <= i_cls_en_wd;
          o_det_en <= i_det_en_wd;
        end else begin
          if (i_rcls_btn && semi_auto) o_cls_en <= 1'b1;
          if (i_rdet_btn && semi_auto) o_det_en <= 1'b1;
        end
        if ((i_rcls_btn && (i_mode == `PPC_MODE_MANUAL)) || (i_on_btn && (i_mode == `PPC_MODE_SEMI)))
          arm_q <= 1'b1;                                              // [RQ18]
      end
      o_two_evt <= tec_on && (i_mode != `PPC_MODE_OFF)
                && ((i_mode == `PPC_MODE_AUTO) || o_cls_en || arm_q); // [RQ17] [RQ18]
    end
  end

endmodule

// ### ppc_cmd_regs.v
// command and configuration registers of a four-port power-sourcing controller
// assumes a command front end on i_clk that delivers one-cycle read and write strobes
`timescale 1ns/1ps
`include "ppc_map.vh"

// Overview of operation
// RQ1 - power-off clears voltage, resistance, status
// RQ2 - power-off clears port events and enables
// RQ3 - powered port off: set change events, clear status
// RQ4 - host checks power good before power-off
// RQ5 - reset register bits act once on one
// RQ6 - host waits 1.2 ms before enable write
// RQ7 - clear-all wipes events, enables, releases interrupt
// RQ8 - release-interrupt frees pin, keeps events
// RQ9 - reset-all equals power-up reset
// RQ10 - host checks power good before port reset
// RQ11 - port reset turns off, clears all but resistance
// RQ12 - port reset cancels cool-down lockout
// RQ13 - powered port reset: set change events
// RQ14 - legacy field picks detection sequence
// RQ15 - detection starts on button or enable
// RQ16 - legacy device never powered automatically
// RQ17 - two-event field arms second classification
// RQ18 - two-event applies per operating mode
// RQ19 - nonzero timer releases deferred interrupts periodically
// RQ20 - zero timer passes interrupts at once
// RQ21 - timer field reads back written value
// RQ22 - host keeps timer upper bits at reset
// RQ23 - off and on together powers off
// RQ24 - critical interrupts bypass deferral
module ppc_cmd_regs #(
  parameter PORTS       = 4,
  parameter STEP_CYCLES = `PPC_T_STEP_MS * `PPC_CLK_KHZ
) (
  // clock and reset
  input  wire               i_clk,
  input  wire               i_arst_n,
  // command port
  input  wire               i_wr_stb,
  input  wire               i_rd_stb,
  input  wire [7:0]         i_cmd,
  input  wire [7:0]         i_wdata,
  output reg  [7:0]         o_rdata,
  output reg                o_rd_valid,
  // operating mode
  input  wire [1:0]         i_mode,
  // port engine inputs
  input  wire [PORTS-1:0]   i_pg_in,
  input  wire [PORTS-1:0]   i_cooldown,
  input  wire [PORTS-1:0]   i_fault_off,
  input  wire [PORTS-1:0]   i_det_good,
  input  wire [PORTS-1:0]   i_det_legacy,
  input  wire [PORTS-1:0]   i_clsc_set,
  input  wire [PORTS-1:0]   i_detc_set,
  input  wire [PORTS-1:0]   i_disf_set,
  input  wire [PORTS-1:0]   i_icut_set,
  input  wire [PORTS-1:0]   i_ilim_set,
  input  wire [PORTS-1:0]   i_strt_set,
  // port engine outputs
  output wire [PORTS-1:0]   o_port_power,
  output wire [PORTS-1:0]   o_clear_voltage,
  output wire [PORTS-1:0]   o_clear_resistance,
  output wire [PORTS-1:0]   o_clear_status,
  output wire [PORTS-1:0]   o_cooldown_cancel,
  output wire [PORTS-1:0]   o_detect_go,
  output wire [PORTS-1:0]   o_detect_run,
  output wire [2*PORTS-1:0] o_detect_seq,
  output wire [PORTS-1:0]   o_second_class_arm,
  output reg                o_restart_class,
  output reg  [PORTS-1:0]   o_restart_class_port,
  // system
  output wire               o_soft_reset,
  output wire               o_int_n
);

  // command decode used for every register write; reads decode i_cmd in the read case
  function hit;
    input [7:0] a;
    input [7:0] c;
    begin
      hit = (a == c);
    end
  endfunction

  // configuration registers, soft reset flag and interrupt path state
  reg  [7:0]         leg_sel_q;
  reg  [7:0]         tec_sel_q;
  reg  [7:0]         defer_q;
  reg  [7:0]         int_en_q;
  reg                srst_q;
  reg                int_q;
  reg                act_q;
  reg  [7:0]         dlv_q;

  // write strobes
  wire               wr_pwr;
  wire               wr_rst;
  wire               wr_en;
  wire               wr_restart;
  wire               wr_defer;
  wire               clr_all;
  wire               rel_pin;
  wire               do_srst;

  // per-port state gathered by group
  wire [PORTS-1:0]   pe;
  wire [PORTS-1:0]   pg;
  wire [PORTS-1:0]   cls_en;
  wire [PORTS-1:0]   det_en;
  wire [8*PORTS-1:0] evt_flat;
  reg  [PORTS-1:0]   grp [0:7];
  reg  [7:0]         grp_nz;
  integer            gi;
  integer            pi;

  // interrupt path
  wire               tmr_release;
  wire               release_now;
  wire [7:0]         dlv_d;
  wire [7:0]         seen;
  wire               act;

  assign wr_pwr     = i_wr_stb && hit(i_cmd, `PPC_CMD_PWR_BTN);
  assign wr_rst     = i_wr_stb && hit(i_cmd, `PPC_CMD_RST_BTN);
  assign wr_en      = i_wr_stb && hit(i_cmd, `PPC_CMD_DC_EN);
  assign wr_restart = i_wr_stb && hit(i_cmd, `PPC_CMD_DC_RESTART);
  assign wr_defer   = i_wr_stb && hit(i_cmd, `PPC_CMD_DEFER_TMR);
  assign clr_all    = wr_rst && i_wdata[`PPC_RST_CLR_ALL];                // [RQ5] [RQ7]
  assign rel_pin    = wr_rst && i_wdata[`PPC_RST_REL_PIN];                // [RQ5] [RQ8]
  assign do_srst    = wr_rst && i_wdata[`PPC_RST_ALL];                    // [RQ5] [RQ9]
  assign o_soft_reset = srst_q;

  // configuration register writes and soft reset flag
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      leg_sel_q <= `PPC_RST_VAL8;
      tec_sel_q <= `PPC_RST_VAL8;
      defer_q   <= `PPC_RST_VAL8;
      int_en_q  <= `PPC_RST_VAL8;
      srst_q    <= 1'b0;
    end else if (srst_q) begin
      leg_sel_q <= `PPC_RST_VAL8;                                         // [RQ9]
      tec_sel_q <= `PPC_RST_VAL8;                                         // [RQ9]
      defer_q   <= `PPC_RST_VAL8;                                         // [RQ9]
      int_en_q  <= `PPC_RST_VAL8;                                         // [RQ9]
      srst_q    <= 1'b0;
    end else begin
      srst_q <= do_srst;
      if (i_wr_stb && hit(i_cmd, `PPC_CMD_LEG_SEL))
        leg_sel_q <= i_wdata;
      if (i_wr_stb && hit(i_cmd, `PPC_CMD_TEC_SEL))
        tec_sel_q <= i_wdata;
      if (wr_defer)
        defer_q <= i_wdata;                                               // [RQ21] [RQ22]
      if (clr_all)
        int_en_q <= `PPC_RST_VAL8;                                        // [RQ7]
      else if (i_wr_stb && hit(i_cmd, `PPC_CMD_INT_EN))
        int_en_q <= i_wdata;
    end
  end

  // restart class strobes go straight to the classification engine
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_restart_class      <= 1'b0;
      o_restart_class_port <= {PORTS{1'b0}};
    end else begin
      o_restart_class      <= wr_restart && !srst_q && (|i_wdata[2*PORTS-1:PORTS]);
      o_restart_class_port <= (wr_restart && !srst_q) ? i_wdata[2*PORTS-1:PORTS] : {PORTS{1'b0}};
    end
  end

  // one controller per port
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      wire [7:0] evt_set;

      assign evt_set = ({7'h00, i_clsc_set[p]} << `PPC_EV_CLSC)
                     | ({7'h00, i_detc_set[p]} << `PPC_EV_DETC)
                     | ({7'h00, i_disf_set[p]} << `PPC_EV_DISF)
                     | ({7'h00, i_icut_set[p]} << `PPC_EV_ICUT)
                     | ({7'h00, i_ilim_set[p]} << `PPC_EV_ILIM)
                     | ({7'h00, i_strt_set[p]} << `PPC_EV_STRT);

      // detection sequence select, reserved code falls back to standard
      assign o_detect_seq[2*p+1:2*p] = (leg_sel_q[2*p+1:2*p] == `PPC_LEG_RSVD) ?
                                       `PPC_LEG_STD : leg_sel_q[2*p+1:2*p];         // [RQ14]

      ppc_port_ctl u_port (
        .i_clk        (i_clk),
        .i_arst_n     (i_arst_n),
        .i_srst       (srst_q),
        .i_mode       (i_mode),
        .i_tec_sel    (tec_sel_q[2*p+1:2*p]),
        .i_off_btn    (wr_pwr && i_wdata[PORTS+p]),
        .i_on_btn     (wr_pwr && i_wdata[p]),
        .i_rst_btn    (wr_rst && i_wdata[p]),
        .i_rdet_btn   (wr_restart && i_wdata[p]),
        .i_rcls_btn   (wr_restart && i_wdata[PORTS+p]),
        .i_en_wr      (wr_en),
        .i_cls_en_wd  (i_wdata[PORTS+p]),
        .i_det_en_wd  (i_wdata[p]),
        .i_clr_all    (clr_all),
        .i_pg_in      (i_pg_in[p]),
        .i_cooldown   (i_cooldown[p]),
        .i_fault_off  (i_fault_off[p]),
        .i_det_good   (i_det_good[p]),
        .i_det_legacy (i_det_legacy[p]),
        .i_evt_set    (evt_set),
        .o_pe         (pe[p]),
        .o_pg         (pg[p]),
        .o_evt        (evt_flat[8*p+7:8*p]),
        .o_cls_en     (cls_en[p]),
        .o_det_en     (det_en[p]),
        .o_two_evt    (o_second_class_arm[p]),
        .o_clr_volt   (o_clear_voltage[p]),
        .o_clr_res    (o_clear_resistance[p]),
        .o_clr_stat   (o_clear_status[p]),
        .o_cd_cancel  (o_cooldown_cancel[p]),
        .o_det_go     (o_detect_go[p]),
        .o_det_run    (o_detect_run[p])
      );
    end
  endgenerate

  assign o_port_power = pe;

  // regroup events as one vector per event kind
  always @* begin
    for (gi = 0; gi < 8; gi = gi + 1) begin
      for (pi = 0; pi < PORTS; pi = pi + 1)
        grp[gi][pi] = evt_flat[8*pi+gi];
      grp_nz[gi] = |grp[gi];
    end
  end

  // deferral timer for non-critical events
  ppc_defer_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_defer (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_srst    (srst_q),
    .i_load    (wr_defer),
    .i_count   (wr_defer ? i_wdata[3:0] : defer_q[3:0]),
    .o_release (tmr_release)
  );

  assign release_now = (defer_q[3:0] == `PPC_RST_VAL4) || tmr_release;    // [RQ19] [RQ20]
  // a delivered group stays delivered while its events remain pending
  assign dlv_d = (dlv_q & grp_nz) | ({8{release_now}} & grp_nz);
  assign seen  = (dlv_d & `PPC_EV_NC_MASK) | (grp_nz & ~`PPC_EV_NC_MASK); // [RQ24]
  assign act   = |(seen & int_en_q);

  // interrupt pin latch, a new event wins over a release in the same cycle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dlv_q <= `PPC_RST_VAL8;
      act_q <= 1'b0;
      int_q <= 1'b0;
    end else if (srst_q) begin
      dlv_q <= `PPC_RST_VAL8;
      act_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      dlv_q <= dlv_d;
      act_q <= act;
      if (act && !act_q)
        int_q <= 1'b1;
      else if (clr_all || rel_pin)
        int_q <= 1'b0;                                                    // [RQ7] [RQ8]
    end
  end

  assign o_int_n = ~int_q;

  // register reads, write-only and unmapped commands read as zero
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata    <= `PPC_RST_VAL8;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        case (i_cmd)
          `PPC_CMD_PWR_EVT:   o_rdata <= {grp[`PPC_EV_PGC],  grp[`PPC_EV_PEC]};
          `PPC_CMD_DET_EVT:   o_rdata <= {grp[`PPC_EV_CLSC], grp[`PPC_EV_DETC]};
          `PPC_CMD_FLT_EVT:   o_rdata <= {grp[`PPC_EV_DISF], grp[`PPC_EV_ICUT]};
          `PPC_CMD_SLI_EVT:   o_rdata <= {grp[`PPC_EV_ILIM], grp[`PPC_EV_STRT]};
          `PPC_CMD_PWR_STAT:  o_rdata <= {pg, pe};
          `PPC_CMD_INT_EN:    o_rdata <= int_en_q;
          `PPC_CMD_DC_EN:     o_rdata <= {cls_en, det_en};
          `PPC_CMD_LEG_SEL:   o_rdata <= leg_sel_q;
          `PPC_CMD_TEC_SEL:   o_rdata <= tec_sel_q;
          `PPC_CMD_DEFER_TMR: o_rdata <= defer_q;                         // [RQ21]
          default:            o_rdata <= `PPC_RST_VAL8;
        endcase
      end
    end
  end

endmodule

// ### ppc_cmd_regs_assertions.sv
// assertions on the port command register block
// bound into ppc_cmd_regs, sees its ports only
`timescale 1ns/1ps
module ppc_cmd_regs_chk (
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_wr_stb,
  input wire logic       i_rd_stb,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_cooldown,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rd_valid,
  input wire logic [3:0] o_port_power,
  input wire logic [3:0] o_clear_resistance,
  input wire logic [3:0] o_clear_status,
  input wire logic [3:0] o_cooldown_cancel,
  input wire logic [3:0] o_detect_go,
  input wire logic       o_soft_reset,
  input wire logic       o_int_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire        off_w = i_wr_stb && i_cmd == 8'h19;
  wire        rst_w = i_wr_stb && i_cmd == 8'h1a;
  wire  [3:0] hi    = i_wdata[7:4];
  wire  [3:0] lo    = i_wdata[3:0];
  logic [7:0] tmr_q;
  // last value written to the deferral timer
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) tmr_q <= 8'h00;
    else if (o_soft_reset) tmr_q <= 8'h00;
    else if (i_wr_stb && i_cmd == 8'h27) tmr_q <= i_wdata;
  end
  sequence s_srst;
    o_soft_reset ##1 (o_port_power == 4'h0 && o_int_n);
  endsequence
  chk_off_clear: assert property (off_w |=> o_clear_resistance == $past(hi) && o_clear_status == $past(hi))
    else $error("off write clears wrong ports");
  chk_off_unpower: assert property (off_w |=> (o_port_power & $past(hi)) == 4'h0)
    else $error("port still powered after off");
  chk_port_reset: assert property (rst_w |=> o_clear_status == $past(lo) && o_clear_resistance == 4'h0)
    else $error("port reset clears wrong items");
  chk_cool_cancel: assert property (rst_w |=> o_cooldown_cancel == ($past(lo) & $past(i_cooldown)))
    else $error("cool-down cancel wrong");
  chk_irq_release: assert property (rst_w && i_wdata[7:6] != 2'h0 |=> o_int_n)
    else $error("interrupt not released");
  chk_soft_reset: assert property (rst_w && i_wdata[4] |=> s_srst)
    else $error("soft reset incomplete");
  chk_tmr_readback: assert property (i_rd_stb && i_cmd == 8'h27 |=> o_rd_valid && o_rdata == tmr_q)
    else $error("timer read not last written");
  chk_detect_go: assert property (i_wr_stb && i_cmd == 8'h18 |=> o_detect_go == $past(lo))
    else $error("detect restart wrong");
endmodule
bind ppc_cmd_regs ppc_cmd_regs_chk chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .i_cmd(i_cmd), .i_wdata(i_wdata), .i_cooldown(i_cooldown), .o_rdata(o_rdata),
  .o_rd_valid(o_rd_valid), .o_port_power(o_port_power), .o_clear_resistance(o_clear_resistance),
  .o_clear_status(o_clear_status), .o_cooldown_cancel(o_cooldown_cancel), .o_detect_go(o_detect_go),
  .o_soft_reset(o_soft_reset), .o_int_n(o_int_n));

// ### ppc_host_model.sv
// host model: issues register commands as one-cycle strobes
// assumes its tasks are called from one process of the bench
`timescale 1ns/1ps
module ppc_host_model (
  // clock
  input  wire logic       i_clk,
  // port state seen by the host
  input  wire logic [3:0] i_pe,
  input  wire logic [3:0] i_pg,
  // command strobes
  output logic            o_wr_stb = 1'b0,
  output logic            o_rd_stb = 1'b0,
  output logic      [7:0] o_cmd    = 8'h00,
  output logic      [7:0] o_wdata  = 8'h00
);
  realtime t_hold = -1.0e9;
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = (c == 8'h27) ? {4'h0, d[3:0]} : d;
    for (int n = 0; n < 50 && (c == 8'h19 || c == 8'h1a) && (i_pe & ~i_pg) != 4'h0; n++)
      @(posedge i_clk);
    while (c == 8'h14 && $realtime - t_hold < 1.2e6) @(posedge i_clk);
    @(posedge i_clk);
    o_wr_stb <= 1'b1;
    o_cmd    <= c;
    o_wdata  <= v;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    if (c == 8'h19 || c == 8'h1a) t_hold = $realtime;
  endtask
  task automatic rd(input logic [7:0] c);
    @(posedge i_clk);
    o_rd_stb <= 1'b1;
    o_cmd    <= c;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
  endtask
endmodule

// ### ppc_tb.sv
// self-checking bench of the port command register block
// commands go through the host model; reads are checked in order
`timescale 1ns/1ps
`include "ppc_map.vh"
module testbench;
  logic       i_clk    = 1'b0;
  logic       i_arst_n = 1'b0;
  logic [1:0] mode     = 2'h1;
  logic [3:0] pg       = 4'h0;
  logic [3:0] cd       = 4'h0;
  logic [3:0] sv [6]   = '{default: 4'h0};
  logic       wr, rs, rv, int_n;
  logic [7:0] cmd, wd, rdata, dseq, d;
  logic [3:0] pe, run;
  logic [7:0] exq [$];
  int         miscompares = 0;
  int         checks_done = 0;
  int         n;
  always #50 i_clk = ~i_clk;
  ppc_host_model hm (.i_clk(i_clk), .i_pe(pe), .i_pg(pg), .o_wr_stb(wr), .o_rd_stb(rs), .o_cmd(cmd), .o_wdata(wd));
  ppc_cmd_regs #(.STEP_CYCLES(20)) dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_stb(wr), .i_rd_stb(rs),
    .i_cmd(cmd), .i_wdata(wd), .o_rdata(rdata), .o_rd_valid(rv), .i_mode(mode), .i_pg_in(pg), .i_cooldown(cd),
    .i_fault_off(4'h0), .i_det_good(4'h0), .i_det_legacy(4'h0), .i_clsc_set(sv[0]), .i_detc_set(sv[1]),
    .i_disf_set(sv[2]), .i_icut_set(sv[3]), .i_ilim_set(sv[4]), .i_strt_set(sv[5]), .o_port_power(pe),
    .o_clear_voltage(), .o_clear_resistance(), .o_clear_status(), .o_cooldown_cancel(), .o_detect_go(),
    .o_detect_run(run), .o_detect_seq(dseq), .o_second_class_arm(), .o_restart_class(),
    .o_restart_class_port(), .o_soft_reset(), .o_int_n(int_n));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exq.push_back(e);
    hm.rd(c);
  endtask
  task automatic pulse(input int g, input logic [3:0] v);
    @(posedge i_clk);
    sv[g] <= v;
    @(posedge i_clk);
    sv[g] <= 4'h0;
  endtask
  always @(posedge i_clk) begin
    if (rv === 1'b1) cmp(rdata, exq.size() > 0 ? exq.pop_front() : 8'hxx);
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    miscompares++;
    results;
  end
  initial begin
    void'($urandom(32'ha9f8));
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`PPC_CMD_LEG_SEL, 8'h00);
    rd(`PPC_CMD_RST_BTN, 8'h00);
    for (int k = 0; k < 4; k++) begin
      hm.wr(`PPC_CMD_LEG_SEL, {4{k[1:0]}});
      rd(`PPC_CMD_LEG_SEL, {4{k[1:0]}});
      cmp(dseq, (k == 3) ? 8'h00 : {4{k[1:0]}});
      hm.wr(`PPC_CMD_TEC_SEL, {4{k[1:0]}});
      rd(`PPC_CMD_TEC_SEL, {4{k[1:0]}});
    end
    d = 8'($urandom);
    hm.wr(`PPC_CMD_DEFER_TMR, d);
    rd(`PPC_CMD_DEFER_TMR, {4'h0, d[3:0]});
    hm.wr(`PPC_CMD_DEFER_TMR, 8'h00);
    hm.wr(`PPC_CMD_DC_EN, 8'hff);
    hm.wr(`PPC_CMD_PWR_BTN, 8'h0f);
    pg <= 4'hf;
    hm.wr(`PPC_CMD_INT_EN, 8'hff);
    hm.wr(`PPC_CMD_RST_BTN, 8'h80);
    rd(`PPC_CMD_PWR_EVT, 8'h00);
    rd(`PPC_CMD_INT_EN, 8'h00);
    for (int g = 0; g < 6; g++) pulse(g, 4'hf);
    hm.wr(`PPC_CMD_PWR_BTN, 8'h11);
    pg <= 4'he;
    rd(`PPC_CMD_PWR_STAT, 8'hee);
    rd(`PPC_CMD_PWR_EVT, 8'h11);
    rd(`PPC_CMD_DET_EVT, 8'hee);
    rd(`PPC_CMD_FLT_EVT, 8'hee);
    rd(`PPC_CMD_SLI_EVT, 8'hee);
    rd(`PPC_CMD_DC_EN, 8'hee);
    cd <= 4'h4;
    hm.wr(`PPC_CMD_RST_BTN, 8'h06);
    pg <= 4'h8;
    cd <= 4'h0;
    rd(`PPC_CMD_PWR_STAT, 8'h88);
    rd(`PPC_CMD_PWR_EVT, 8'h77);
    rd(`PPC_CMD_DET_EVT, 8'h88);
    rd(`PPC_CMD_DC_EN, 8'h88);
    hm.wr(`PPC_CMD_RST_BTN, 8'h80);
    hm.wr(`PPC_CMD_INT_EN, 8'h01);
    hm.wr(`PPC_CMD_PWR_BTN, 8'h80);
    pg <= 4'h0;
    repeat (3) @(posedge i_clk);
    cmp({7'h0, int_n}, 8'h00);
    hm.wr(`PPC_CMD_RST_BTN, 8'h40);
    repeat (2) @(posedge i_clk);
    cmp({7'h0, int_n}, 8'h01);
    rd(`PPC_CMD_PWR_EVT, 8'h88);
    rd(`PPC_CMD_INT_EN, 8'h01);
    hm.wr(`PPC_CMD_RST_BTN, 8'h80);
    hm.wr(`PPC_CMD_INT_EN, 8'h04);
    hm.wr(`PPC_CMD_DEFER_TMR, 8'h02);
    pulse(1, 4'h1);
    repeat (10) @(posedge i_clk);
    cmp({7'h0, int_n}, 8'h01);
    for (n = 0; n < 60 && int_n !== 1'b0; n++) @(posedge i_clk);
    cmp({7'h0, n >= 20 && n <= 36}, 8'h01);
    hm.wr(`PPC_CMD_RST_BTN, 8'h80);
    hm.wr(`PPC_CMD_INT_EN, 8'h10);
    pulse(2, 4'h1);
    repeat (3) @(posedge i_clk);
    cmp({7'h0, int_n}, 8'h00);
    hm.wr(`PPC_CMD_RST_BTN, 8'h10);
    repeat (3) @(posedge i_clk);
    cmp({7'h0, int_n}, 8'h01);
    rd(`PPC_CMD_DEFER_TMR, 8'h00);
    rd(`PPC_CMD_LEG_SEL, 8'h00);
    rd(`PPC_CMD_INT_EN, 8'h00);
    mode <= 2'h2;
    hm.wr(`PPC_CMD_DC_EN, 8'h0f);
    repeat (2) @(posedge i_clk);
    cmp({4'h0, run}, 8'h0f);
    hm.wr(`PPC_CMD_DC_RESTART, 8'h0f);
    mode <= 2'h0;
    repeat (2) @(posedge i_clk);
    cmp({4'h0, run}, 8'h00);
    results;
  end
endmodule
